// >>> common/csi_pkg.sv
// Contract
// - writing the halt-release enable bit as one forces block mode to zero.
// - receive select zero transmits; one receives, or exchanges in mode 0.
// - setting active starts; clearing it mid-transfer aborts; software clears irq_enable too.
// - mode 0 ends at the last rising clock edge: set done, clear active; code sets done and clears active in ST_END, after the 6-cycle ST_STORE state.
// - mode 1 transmit ends at last rising edge: set done, clear active; code does both in ST_END, after the 6-cycle ST_STORE state.
// - mode 1 receive or exchange ends after the last byte reaches RAM.
// - mode decoded from halt release, exchange, block mode and receive select; code decodes only exchange, block mode and receive select.
// - clearing block mode mid-transfer suspends after the current byte; setting resumes.
// - bit order select zero shifts LSB first, one shifts MSB first.
// - falling serial clock edge while not active sets the sticky overrun flag.
// - mode 0 falling edge during startup or termination sets overrun.
// - mode 1 transmit falling edge before the fetched byte starts shifting sets overrun.
// - mode 1 receive falling edge from last rising edge until stored sets overrun.
// - done flag set on completion; only a software write clears it.
// - interrupt request when irq_enable and either done or overrun are set.
// - internal bit clock period is (reload + 1) times 2 system cycles.
// - data buffer copied to shift register at start; back at end on receive.
// - mode 1 internal clock inserts byte gap of period times 0..64.
// - residual count 000 means 8 bits, else 1 to 7; sets mode 0 length.
// - mode 1 length is (count + 1) times 8 plus residual bits.
package csi_pkg;
    localparam logic [15:0] ADDR_CONTROL = 16'h7f34;
    localparam logic [15:0] ADDR_RELOAD = 16'h7f35;
    localparam logic [15:0] ADDR_DATA = 16'h7f36;
    localparam logic [15:0] ADDR_INTERVAL = 16'h7f37;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam int CTL_HALT_REL = 7;
    localparam int CTL_RX = 6;
    localparam int CTL_ACTIVE = 5;
    localparam int CTL_BLOCK = 4;
    localparam int CTL_MSB = 3;
    localparam int CTL_OVR = 2;
    localparam int CTL_DONE = 1;
    localparam int CTL_IE = 0;
    localparam int IV_XCHG = 3;
    localparam int XFER_CYCLES = 6;
    localparam logic [3:0] FULL_BITS = 4'h8;
    localparam logic [11:0] MAX_BYTES = 12'hfff;
    typedef enum logic [2:0] {
        ST_IDLE, ST_START, ST_SHIFT, ST_STORE, ST_GAP, ST_FETCH, ST_END
    } csi_state_t;
endpackage

// >>> rtl/csi_bitclk.sv
`timescale 1ns/1ns
// internal bit clock generator: reload counter, toggles every reload+1 cycles
module csi_bitclk (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic run,
    input wire logic [7:0] reload,
    output logic sck,
    output logic rise,
    output logic fall
);
    logic [7:0] cnt_reg;
    logic sck_reg;
    logic tick;

    assign tick = run && (cnt_reg == reload);
    assign sck = sck_reg;
    assign rise = tick && !sck_reg;
    assign fall = tick && sck_reg;

    // period (reload + 1) * 2 cycles
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= 8'h00;
        end else if (!run || tick) begin
            cnt_reg <= 8'h00;
        end else begin
            cnt_reg <= cnt_reg + 8'h01;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sck_reg <= 1'b1;
        end else if (!run) begin
            sck_reg <= 1'b1;
        end else if (tick) begin
            sck_reg <= !sck_reg;
        end
    end
endmodule

// >>> rtl/csi_serial_unit.sv
`timescale 1ns/1ns
module csi_serial_unit (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [15:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic sck_in,
    output logic sck_out,
    output logic sck_oe_n,
    input wire logic sdi,
    output logic sdo,
    input wire logic [11:0] dma_count,
    output logic dma_req,
    output logic dma_write,
    output logic [7:0] dma_wdata,
    input wire logic dma_ack,
    input wire logic [7:0] dma_rdata,
    output logic irq
);
    // ==========================================================
    // registers
    logic [7:0] ctl_reg;
    logic [7:0] reload_reg;
    logic [7:0] buf_reg;
    logic [7:0] xbuf_reg;
    logic [7:0] ivl_reg;
    logic [7:0] sh_reg;
    logic [7:0] rdata_reg;
    logic sdo_reg;
    csi_pkg::csi_state_t st_reg;
    logic [3:0] bit_reg;
    logic [11:0] byte_reg;
    logic [7:0] gap_reg;
    logic [2:0] wait_reg;
    logic sck_m_reg;
    logic sck_s_reg;
    logic sck_d_reg;
    logic sdi_m_reg;
    logic sdi_s_reg;
    logic [8:0] gcyc_reg;
    logic auto_run_reg;

    logic wr_ctl;
    logic ext_clk;
    logic auto_mode;
    logic rx_mode;
    logic xchg_mode;
    logic msb;
    logic active;
    logic int_sck;
    logic int_rise;
    logic int_fall;
    logic ext_fall;
    logic s_rise;
    logic s_fall;
    logic [3:0] last_bits;
    logic last_byte;
    logic bit_done;
    logic [7:0] gap_len;
    logic finish;
    logic ovr_set;
    logic abort;
    logic [7:0] sh_in;

    assign wr_ctl = reg_wr && reg_addr == csi_pkg::ADDR_CONTROL;
    assign ext_clk = reload_reg == 8'h00;
    assign auto_mode = ctl_reg[csi_pkg::CTL_BLOCK];
    assign rx_mode = ctl_reg[csi_pkg::CTL_RX];
    assign xchg_mode = ivl_reg[csi_pkg::IV_XCHG];
    assign msb = ctl_reg[csi_pkg::CTL_MSB];
    assign active = ctl_reg[csi_pkg::CTL_ACTIVE];
    assign abort = wr_ctl && !reg_wdata[csi_pkg::CTL_ACTIVE];

    // ==========================================================
    // serial clock sampling and internal clock
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sck_m_reg <= 1'b1;
            sck_s_reg <= 1'b1;
            sck_d_reg <= 1'b1;
            sdi_m_reg <= 1'b0;
            sdi_s_reg <= 1'b0;
        end else begin
            sck_m_reg <= sck_in;
            sck_s_reg <= sck_m_reg;
            sck_d_reg <= sck_s_reg;
            sdi_m_reg <= sdi;
            sdi_s_reg <= sdi_m_reg;
        end
    end

    csi_bitclk u_bitclk (
        .clock(clock),
        .rst_n(rst_n),
        .run(active && !ext_clk && st_reg == csi_pkg::ST_SHIFT),
        .reload(reload_reg),
        .sck(int_sck),
        .rise(int_rise),
        .fall(int_fall)
    );

    assign ext_fall = sck_d_reg && !sck_s_reg;
    assign s_rise = ext_clk ? (!sck_d_reg && sck_s_reg) : int_rise;
    assign s_fall = ext_clk ? ext_fall : int_fall;
    assign sck_out = int_sck;
    assign sck_oe_n = ext_clk;
    assign sdo = sdo_reg;

    // ==========================================================
    // length and gap decode
    assign last_bits = (ivl_reg[6:4] == 3'b000) ? csi_pkg::FULL_BITS
                                                : {1'b0, ivl_reg[6:4]};
    assign last_byte = !auto_run_reg || byte_reg == dma_count + 12'h001;
    assign bit_done = bit_reg == (last_byte ? last_bits : csi_pkg::FULL_BITS);

    always_comb begin
        unique case (ivl_reg[2:0])
            3'b000: gap_len = 8'h00;
            3'b001: gap_len = 8'h01;
            3'b010: gap_len = 8'h02;
            3'b011: gap_len = 8'h04;
            3'b100: gap_len = 8'h08;
            3'b101: gap_len = 8'h10;
            3'b110: gap_len = 8'h20;
            3'b111: gap_len = 8'h40;
        endcase
    end

    assign sh_in = msb ? {sh_reg[6:0], sdi_s_reg} : {sdi_s_reg, sh_reg[7:1]};

    // ==========================================================
    // transfer sequencer
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= csi_pkg::ST_IDLE;
            bit_reg <= 4'h0;
            byte_reg <= 12'h000;
            gap_reg <= 8'h00;
            wait_reg <= 3'h0;
            sh_reg <= csi_pkg::RESET_BYTE;
            sdo_reg <= 1'b1;
            auto_run_reg <= 1'b0;
        end else if (abort && st_reg != csi_pkg::ST_IDLE) begin
            st_reg <= csi_pkg::ST_IDLE;
        end else begin
            unique case (st_reg)
                csi_pkg::ST_IDLE: begin
                    if (active) begin
                        byte_reg <= 12'h000;
                        auto_run_reg <= auto_mode;
                        st_reg <= auto_mode && !rx_mode || xchg_mode
                                  ? csi_pkg::ST_FETCH : csi_pkg::ST_START;
                    end
                end
                csi_pkg::ST_FETCH: begin
                    if (dma_ack) begin
                        st_reg <= csi_pkg::ST_START;
                    end
                end
                csi_pkg::ST_START: begin
                    sh_reg <= buf_reg;
                    sdo_reg <= msb ? buf_reg[7] : buf_reg[0];
                    bit_reg <= 4'h0;
                    wait_reg <= 3'h0;
                    st_reg <= csi_pkg::ST_SHIFT;
                end
                csi_pkg::ST_SHIFT: begin
                    if (s_fall && bit_reg != 4'h0) begin
                        sdo_reg <= msb ? sh_reg[7] : sh_reg[0];
                    end
                    if (s_rise) begin
                        sh_reg <= sh_in;
                        bit_reg <= bit_reg + 4'h1;
                    end
                    if (bit_reg != 4'h0 && bit_done) begin
                        st_reg <= csi_pkg::ST_STORE;
                        wait_reg <= 3'h0;
                    end
                end
                csi_pkg::ST_STORE: begin
                    // shift register to buffer move takes 6 cycles
                    wait_reg <= wait_reg + 3'h1;
                    if (wait_reg == 3'(csi_pkg::XFER_CYCLES - 1)) begin
                        if (!auto_run_reg || !rx_mode || dma_ack) begin
                            byte_reg <= byte_reg + 12'h001;
                            gap_reg <= 8'h00;
                            st_reg <= last_byte || !auto_run_reg
                                      ? csi_pkg::ST_END : csi_pkg::ST_GAP;
                        end else begin
                            wait_reg <= wait_reg;
                        end
                    end
                end
                csi_pkg::ST_GAP: begin
                    if (ext_clk || gap_reg >= gap_len) begin
                        if (auto_mode) begin
                            st_reg <= (!rx_mode || xchg_mode)
                                      ? csi_pkg::ST_FETCH
                                      : csi_pkg::ST_START;
                        end
                    end else if (gcyc_reg == {reload_reg, 1'b1}) begin
                        gap_reg <= gap_reg + 8'h01;
                    end
                end
                csi_pkg::ST_END: begin
                    st_reg <= csi_pkg::ST_IDLE;
                end
                default: st_reg <= csi_pkg::ST_IDLE;
            endcase
        end
    end

    // gap counts whole bit clock periods of (reload + 1) * 2 cycles
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            gcyc_reg <= 9'h000;
        end else if (st_reg != csi_pkg::ST_GAP
                     || gcyc_reg == {reload_reg, 1'b1}) begin
            gcyc_reg <= 9'h000;
        end else begin
            gcyc_reg <= gcyc_reg + 9'h001;
        end
    end

    assign finish = st_reg == csi_pkg::ST_END;

    // ==========================================================
    // companion transfer controller requests
    always_comb begin
        dma_req = 1'b0;
        dma_write = 1'b0;
        if (st_reg == csi_pkg::ST_FETCH) begin
            dma_req = 1'b1;
        end else if (st_reg == csi_pkg::ST_STORE && auto_run_reg && rx_mode
                     && wait_reg == 3'(csi_pkg::XFER_CYCLES - 1)) begin
            dma_req = 1'b1;
            dma_write = 1'b1;
        end
    end
    assign dma_wdata = xchg_mode ? xbuf_reg : buf_reg;

    // ==========================================================
    // overrun window
    always_comb begin
        ovr_set = 1'b0;
        if (ext_fall) begin
            if (!active) begin
                ovr_set = 1'b1;
            end else if (st_reg == csi_pkg::ST_START
                         || st_reg == csi_pkg::ST_END) begin
                ovr_set = 1'b1;
            end else if (st_reg == csi_pkg::ST_FETCH) begin
                ovr_set = 1'b1;
            end else if (st_reg == csi_pkg::ST_STORE && auto_mode
                         && rx_mode && last_byte) begin
                ovr_set = 1'b1;
            end
        end
    end

    // ==========================================================
    // control register
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ctl_reg <= csi_pkg::RESET_BYTE;
        end else begin
            if (wr_ctl) begin
                ctl_reg <= reg_wdata;
                if (reg_wdata[csi_pkg::CTL_HALT_REL]) begin
                    ctl_reg[csi_pkg::CTL_BLOCK] <= 1'b0;
                end
            end
            if (finish) begin
                ctl_reg[csi_pkg::CTL_ACTIVE] <= 1'b0;
                ctl_reg[csi_pkg::CTL_DONE] <= 1'b1;
            end
            if (ovr_set) begin
                ctl_reg[csi_pkg::CTL_OVR] <= 1'b1;
            end
        end
    end

    assign irq = ctl_reg[csi_pkg::CTL_IE]
                 && (ctl_reg[csi_pkg::CTL_DONE] || ctl_reg[csi_pkg::CTL_OVR]);

    // ==========================================================
    // data buffers and setup registers
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            buf_reg <= csi_pkg::RESET_BYTE;
            xbuf_reg <= csi_pkg::RESET_BYTE;
        end else begin
            if (reg_wr && reg_addr == csi_pkg::ADDR_DATA) begin
                buf_reg <= reg_wdata;
            end
            if (st_reg == csi_pkg::ST_FETCH && dma_ack) begin
                buf_reg <= dma_rdata;
            end
            if (st_reg == csi_pkg::ST_STORE && wait_reg == 3'h0 && rx_mode) begin
                if (xchg_mode) begin
                    xbuf_reg <= sh_reg;
                end else begin
                    buf_reg <= sh_reg;
                end
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            reload_reg <= csi_pkg::RESET_BYTE;
            ivl_reg <= csi_pkg::RESET_BYTE;
        end else begin
            if (reg_wr && reg_addr == csi_pkg::ADDR_RELOAD) begin
                reload_reg <= reg_wdata;
            end
            if (reg_wr && reg_addr == csi_pkg::ADDR_INTERVAL) begin
                ivl_reg <= {1'b0, reg_wdata[6:0]};
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rdata_reg <= 8'h00;
        end else if (reg_rd) begin
            unique case (reg_addr)
                csi_pkg::ADDR_CONTROL: rdata_reg <= ctl_reg;
                csi_pkg::ADDR_RELOAD: rdata_reg <= reload_reg;
                csi_pkg::ADDR_DATA: rdata_reg <= buf_reg;
                csi_pkg::ADDR_INTERVAL: rdata_reg <= ivl_reg;
                default: rdata_reg <= 8'h00;
            endcase
        end else begin
            rdata_reg <= 8'h00;
        end
    end
    assign reg_rdata = rdata_reg;
endmodule

// >>> test/csi_serial_unit_chk.sv
`timescale 1ns/1ns
module csi_serial_unit_chk (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [15:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic sck_out,
    input wire logic sck_oe_n,
    input wire logic irq
);
    // ====
    // shadows of software traffic
    logic [7:0] reload_reg;
    logic [8:0] low_cnt_reg;
    logic rd_ctl_reg;
    logic ovr_seen_reg;
    logic done_seen_reg;
    wire ctl_wr = reg_wr && reg_addr == csi_pkg::ADDR_CONTROL;
    wire ctl_rd = reg_rd && reg_addr == csi_pkg::ADDR_CONTROL;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            reload_reg <= 8'h00;
        end else if (reg_wr && reg_addr == csi_pkg::ADDR_RELOAD) begin
            reload_reg <= reg_wdata;
        end
    end
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n || sck_out) begin
            low_cnt_reg <= 9'h000;
        end else begin
            low_cnt_reg <= low_cnt_reg + 9'h001;
        end
    end
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rd_ctl_reg <= 1'b0;
        end else begin
            rd_ctl_reg <= ctl_rd;
        end
    end
    // flags seen set stay set until software writes control
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n || ctl_wr) begin
            ovr_seen_reg <= 1'b0;
            done_seen_reg <= 1'b0;
        end else if (rd_ctl_reg) begin
            ovr_seen_reg <= reg_rdata[csi_pkg::CTL_OVR];
            done_seen_reg <= reg_rdata[csi_pkg::CTL_DONE];
        end
    end
    // ====
    // properties
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);
    sequence halt_wr_s;
        ctl_wr && reg_wdata[csi_pkg::CTL_HALT_REL];
    endsequence
    sequence ctl_rd_s;
        ctl_rd;
    endsequence
    halt_block_a: assert property (
        halt_wr_s ##[1:2] ctl_rd_s |=> !reg_rdata[csi_pkg::CTL_BLOCK])
        else $error("block mode kept after halt release write");
    irq_match_a: assert property (
        $past(ctl_rd) |-> $past(irq) == (reg_rdata[0] & |reg_rdata[2:1]))
        else $error("irq differs from enable and flags");
    unmapped_zero_a: assert property ($past(reg_rd) &&
        ($past(reg_addr) < csi_pkg::ADDR_CONTROL ||
        $past(reg_addr) > csi_pkg::ADDR_INTERVAL) |-> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside read cycle");
    ivl_bit7_a: assert property ($past(reg_rd) &&
        $past(reg_addr) == csi_pkg::ADDR_INTERVAL |-> !reg_rdata[7])
        else $error("interval bit 7 reads one");
    ovr_sticky_a: assert property (
        rd_ctl_reg && ovr_seen_reg |-> reg_rdata[csi_pkg::CTL_OVR])
        else $error("overrun flag cleared without write");
    done_sticky_a: assert property (
        rd_ctl_reg && done_seen_reg |-> reg_rdata[csi_pkg::CTL_DONE])
        else $error("done flag cleared without write");
    bitclk_low_a: assert property (
        $rose(sck_out) && reload_reg != 8'h00 |->
        low_cnt_reg == {1'b0, reload_reg} + 9'h001)
        else $error("bit clock low phase length wrong");
    ext_clk_oe_a: assert property (
        reload_reg == 8'h00 && $past(reload_reg) == 8'h00 |-> sck_oe_n)
        else $error("clock driven with zero reload");
endmodule
bind csi_serial_unit csi_serial_unit_chk u_chk (.clock(clock),
    .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .sck_out(sck_out), .sck_oe_n(sck_oe_n), .irq(irq));

// >>> test/csi_peer.sv
`timescale 1ns/1ns
module csi_peer (
    input wire logic clock,
    input wire logic sck_line,
    input wire logic sdo,
    input wire logic gen,
    input wire logic frame,
    input wire logic msb,
    input wire logic [3:0] nclk,
    input wire logic [7:0] tx,
    output logic sck_ext,
    output logic sdi,
    output logic [7:0] rx
);
    int idx;
    initial begin
        sck_ext = 1'b1;
        sdi = 1'b1;
        rx = 8'h00;
        idx = 0;
    end
    // ====
    // link clock stands high between frames
    always @(posedge gen) begin
        // keep link edges off the system clock edges
        #5;
        repeat (nclk) begin
            #80 sck_ext = 1'b0;
            #80 sck_ext = 1'b1;
        end
    end
    // ====
    // new bit after each fall, capture on each rise
    always @(negedge sck_line) begin
        if (frame) begin
            sdi <= msb ? tx[7 - idx[2:0]] : tx[idx[2:0]];
            idx <= idx + 1;
        end
    end
    always @(posedge sck_line) begin
        if (frame) begin
            rx <= msb ? {rx[6:0], sdo} : {sdo, rx[7:1]};
        end
    end
    // no stale level outside frames
    always @(posedge clock) begin
        if (!frame) begin
            sdi <= ~sdi;
            idx <= 0;
            rx <= 8'h00;
        end
    end
endmodule

// >>> test/csi_serial_unit_tb.sv
`timescale 1ns/1ns
module csi_serial_unit_tb;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic [15:0] reg_addr = 16'h0000;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata, dma_wdata, peer_rx, last_store;
    logic sck_out, sck_oe_n, sdo, sdi, sck_ext, dma_req, dma_write, irq;
    logic [11:0] dma_count = 12'h000;
    logic dma_ack = 1'b0;
    logic [7:0] dma_rdata = 8'h00;
    logic [7:0] peer_tx = 8'h00;
    logic gen = 1'b0;
    logic frame = 1'b0;
    logic msb = 1'b0;
    logic [3:0] nclk = 4'h0;
    logic [7:0] mem [4];
    int failures = 0;
    int samples_checked = 0;
    int cycles = 0;
    int n_dma = 0;
    int seed = 32'h0f64_6909;
    wire sck_line = sck_oe_n ? sck_ext : sck_out;
    always #10 clock = ~clock;
    csi_serial_unit dut (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .sck_in(sck_line), .sck_out(sck_out),
        .sck_oe_n(sck_oe_n), .sdi(sdi), .sdo(sdo), .dma_count(dma_count),
        .dma_req(dma_req), .dma_write(dma_write), .dma_wdata(dma_wdata),
        .dma_ack(dma_ack), .dma_rdata(dma_rdata), .irq(irq));
    csi_peer peer (.clock(clock), .sck_line(sck_line), .sdo(sdo), .gen(gen),
        .frame(frame), .msb(msb), .nclk(nclk), .tx(peer_tx),
        .sck_ext(sck_ext), .sdi(sdi), .rx(peer_rx));
    // ====
    // companion transfer controller and watchdog
    always @(posedge clock) begin
        cycles <= cycles + 1;
        dma_ack <= dma_req && !dma_ack;
        if (dma_req && !dma_ack) begin
            dma_rdata <= mem[n_dma[1:0]];
            if (dma_write) last_store <= dma_wdata;
            n_dma <= n_dma + 1;
        end
        if (cycles == 20000) begin
            failures++;
            end_of_test();
        end
    end
    // ====
    // tasks
    task automatic end_of_test();
        $display("checked %0d mismatched %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic chk_reg(input logic [15:0] a, input logic [7:0] m,
        input logic [7:0] exp);
        logic [7:0] d;
        rd(a, d);
        chk(d & m, exp);
    endtask
    task automatic wait_idle();
        logic [7:0] d;
        d = 8'hff;
        for (int i = 0; i < 900 && d[csi_pkg::CTL_ACTIVE] !== 1'b0; i++)
            rd(csi_pkg::ADDR_CONTROL, d);
    endtask
    task automatic pulse_gen();
        repeat (8) @(posedge clock);
        gen <= 1'b1;
        @(posedge clock);
        gen <= 1'b0;
    endtask
    function automatic logic [7:0] exp_rx(logic [7:0] tx, logic m, int n);
        return m ? tx >> (8 - n) : tx << (8 - n);
    endfunction
    task automatic run0(input logic rx_sel, input logic m,
        input logic [2:0] code, input logic [7:0] bv, input logic [7:0] ptx,
        input logic [7:0] rl);
        int n;
        n = (code == 3'b000) ? 8 : int'(code);
        wr(csi_pkg::ADDR_INTERVAL, {1'b0, code, 4'h0});
        wr(csi_pkg::ADDR_RELOAD, rl);
        wr(csi_pkg::ADDR_DATA, bv);
        peer_tx <= ptx;
        msb <= m;
        frame <= 1'b1;
        nclk <= 4'(n);
        wr(csi_pkg::ADDR_CONTROL, {1'b0, rx_sel, 2'b10, m, 3'b000});
        if (rl == 8'h00) pulse_gen();
        wait_idle();
        chk(peer_rx, exp_rx(bv, m, n));
        if (rx_sel && n == 8) chk_reg(csi_pkg::ADDR_DATA, 8'hff, ptx);
        chk_reg(csi_pkg::ADDR_CONTROL, 8'h26, 8'h02);
        frame <= 1'b0;
        wr(csi_pkg::ADDR_CONTROL, 8'h00);
    endtask
    task automatic run1(input logic rx_sel, input logic [11:0] cnt,
        input logic [7:0] ptx, input logic x);
        n_dma <= 0;
        dma_count <= cnt;
        peer_tx <= ptx;
        msb <= 1'b1;
        frame <= 1'b1;
        wr(csi_pkg::ADDR_INTERVAL, {4'h0, x, 3'b001});
        wr(csi_pkg::ADDR_RELOAD, 8'h03);
        wr(csi_pkg::ADDR_CONTROL, {1'b0, rx_sel, 2'b11, 4'h8});
        wait_idle();
        chk(8'(n_dma), (8'(cnt) + 8'h02) << x);
        chk(rx_sel ? last_store : peer_rx, rx_sel ? ptx : mem[cnt + 1]);
        chk_reg(csi_pkg::ADDR_CONTROL, 8'h36, 8'h12);
        frame <= 1'b0;
        wr(csi_pkg::ADDR_CONTROL, 8'h00);
    endtask
    // ====
    // main sequence
    initial begin
        logic [31:0] r;
        for (int i = 0; i < 4; i++)
            mem[i] = 8'($random(seed));
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        for (int i = 0; i < 5; i++)
            chk_reg(csi_pkg::ADDR_CONTROL + 16'(i), 8'hff, 8'h00);
        wr(csi_pkg::ADDR_CONTROL + 16'h0004, 8'h5a);
        chk_reg(csi_pkg::ADDR_CONTROL + 16'h0004, 8'hff, 8'h00);
        for (int i = 1; i < 4; i++) begin
            r = $random(seed);
            wr(csi_pkg::ADDR_CONTROL + 16'(i), r[7:0] & 8'hf7);
            chk_reg(csi_pkg::ADDR_CONTROL + 16'(i), 8'hff,
                r[7:0] & (i == 3 ? 8'h77 : 8'hf7));
        end
        wr(csi_pkg::ADDR_CONTROL, 8'h90);
        chk_reg(csi_pkg::ADDR_CONTROL, 8'h90, 8'h80);
        wr(csi_pkg::ADDR_CONTROL, 8'h00);
        $display("registers test done");
        for (int i = 0; i < 8; i++) begin
            r = $random(seed);
            run0(r[1] | (i == 1), r[2], i == 0 ? 3'b001 :
                (i == 1 ? 3'b000 : r[5:3]), r[15:8], r[23:16],
                r[0] ? 8'h00 : {6'h00, r[25:24]} + 8'h02);
        end
        $display("mode 0 test done");
        run1(1'b0, 12'h000, 8'h00, 1'b0);
        run1(1'b1, 12'h001, 8'(r[31:24]), 1'b0);
        run1(1'b1, 12'h000, 8'(r[23:16]), 1'b1);
        $display("mode 1 test done");
        wr(csi_pkg::ADDR_RELOAD, 8'h00);
        wr(csi_pkg::ADDR_INTERVAL, 8'h00);
        frame <= 1'b1;
        nclk <= 4'h8;
        wr(csi_pkg::ADDR_CONTROL, 8'h21);
        pulse_gen();
        repeat (30) @(posedge clock);
        wr(csi_pkg::ADDR_CONTROL, 8'h00);
        chk_reg(csi_pkg::ADDR_CONTROL, 8'h22, 8'h00);
        repeat (120) @(posedge clock);
        chk_reg(csi_pkg::ADDR_CONTROL, 8'h04, 8'h04);
        wr(csi_pkg::ADDR_CONTROL, 8'h05);
        #1;
        chk({7'h00, irq}, 8'h01);
        wr(csi_pkg::ADDR_CONTROL, 8'h01);
        #1;
        chk({7'h00, irq}, 8'h00);
        chk_reg(csi_pkg::ADDR_CONTROL, 8'h04, 8'h00);
        frame <= 1'b0;
        wr(csi_pkg::ADDR_CONTROL, 8'h00);
        $display("abort test done");
        end_of_test();
    end
endmodule
